// ===== rtl/mrc_top.sv
// address decode, remap, sram and register access for the system control block
// Functional notes
// - accesses outside every defined region answer with a data abort
// - multi-byte data is little endian, low byte at lowest address
// - sram is 1536 words at base 0x00040000
// - sram takes byte, halfword and word accesses; narrow writes touch addressed bytes
// - lowest 94 kB alias flash; when remapped only the lowest 6 kB alias sram, the rest aborts
// - 4 kB register page at 0xFFFF0000 holds all peripheral registers
// - after any reset the alias window shows flash
// - map select bit 0 set maps sram low; clear restores flash
// - every reset source clears the remap selection
// - status bits record power-on, watchdog, software and external resets
// - status and clear bits 7 to 4 unused; status reads zero there
// - writing 1 to status bit 2 triggers a software reset
// - writing 1s to the clear register clears those status bits only
// - clear write leaving a set software bit triggers another software reset
// - every reset resets pins, kernel, peripherals; watchdog only on power-on
// - ram valid across watchdog, software, pin resets, not after download
// - with low voltage flag enabled, power-on ram valid only if flag set
// - reset starts in hidden kernel, then user code at address zero
// - kernel flash region is hidden from user accesses
`timescale 1ns/10ps
module mrc_top #(
  parameter int SRAM_WORDS = mrc_pkg::SRAM_WORDS
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [1:0] size_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic done_o,
  output logic abort_o,
  output logic [31:0] rdata_o,
  output logic flash_rd_o,
  output logic [mrc_pkg::FLASH_AW-1:0] flash_addr_o,
  input wire logic [31:0] flash_rdata_i,
  output logic mmr_req_o,
  output logic mmr_we_o,
  output logic [mrc_pkg::MMR_AW-1:0] mmr_addr_o,
  output logic [3:0] mmr_be_o,
  output logic [31:0] mmr_wdata_o,
  input wire logic [31:0] mmr_rdata_i,
  input wire logic wdt_timeout_i,
  input wire logic ext_reset_i,
  input wire logic lvf_enable_i,
  input wire logic low_voltage_flag_i,
  input wire logic download_done_i,
  input wire logic kernel_done_i,
  output logic sys_reset_o,
  output logic wdt_reset_o,
  output logic kernel_run_o,
  output logic ram_valid_o
);
  typedef struct packed {
    logic remap;
    logic done;
    logic abort;
    logic [31:0] rdata;
  } mrc_bus_s;

  mrc_bus_s s;
  mrc_bus_s next_s;
  mrc_pkg::mrc_region_e region;
  logic misaligned;
  logic [31:0] offset;
  logic [31:0] lane_data;
  logic [3:0] lane_be;
  logic [31:0] word;
  logic [31:0] sram_rdata;
  logic sram_we;
  logic sts_wr;
  logic clr_wr;
  logic [7:0] status;

  ////////////////////////////////////////////////////////////////////////////
  function automatic mrc_pkg::mrc_region_e decode(
    input logic [31:0] a,
    input logic remap,
    input logic kern
  );
    logic [31:0] kbase;
    kbase = mrc_pkg::FLASH_BASE + mrc_pkg::FLASH_SIZE - mrc_pkg::KERNEL_SIZE;
    decode = mrc_pkg::MRC_REGION_NONE;
    if (a < mrc_pkg::ALIAS_SIZE) begin
      // aliased sram is only as large as the array itself
      if (remap) begin
        decode = (a < mrc_pkg::SRAM_SIZE) ? mrc_pkg::MRC_REGION_SRAM
                                          : mrc_pkg::MRC_REGION_NONE;
      end else begin
        decode = mrc_pkg::MRC_REGION_FLASH;
      end
    end else if (a >= mrc_pkg::SRAM_BASE && a < mrc_pkg::SRAM_BASE + mrc_pkg::SRAM_SIZE) begin
      decode = mrc_pkg::MRC_REGION_SRAM;
    end else if (a >= mrc_pkg::FLASH_BASE && a < kbase) begin
      decode = mrc_pkg::MRC_REGION_FLASH;
    end else if (kern && a >= kbase && a < mrc_pkg::FLASH_BASE + mrc_pkg::FLASH_SIZE) begin
      decode = mrc_pkg::MRC_REGION_FLASH;
    end else if (a[31:mrc_pkg::MMR_PAGE_LSB] == mrc_pkg::MMR_BASE[31:mrc_pkg::MMR_PAGE_LSB]) begin
      if (a[31:2] == mrc_pkg::MAP_SELECT_ADDR[31:2]) begin
        decode = mrc_pkg::MRC_REGION_MAP;
      end else if (a[31:2] == mrc_pkg::RST_STATUS_ADDR[31:2]) begin
        decode = mrc_pkg::MRC_REGION_STATUS;
      end else if (a[31:2] == mrc_pkg::RST_CLEAR_ADDR[31:2]) begin
        decode = mrc_pkg::MRC_REGION_CLEAR;
      end else begin
        decode = mrc_pkg::MRC_REGION_MMR;
      end
    end
  endfunction

  function automatic logic [3:0] byte_enables(input logic [1:0] size, input logic [1:0] lo);
    case (size)
      mrc_pkg::MRC_SIZE_BYTE: byte_enables = 4'h1 << lo;
      mrc_pkg::MRC_SIZE_HALF: byte_enables = lo[1] ? 4'hC : 4'h3;
      default: byte_enables = 4'hF;
    endcase
  endfunction

  function automatic logic [31:0] lane_copy(input logic [1:0] size, input logic [31:0] d);
    case (size)
      mrc_pkg::MRC_SIZE_BYTE: lane_copy = {4{d[7:0]}};
      mrc_pkg::MRC_SIZE_HALF: lane_copy = {2{d[15:0]}};
      default: lane_copy = d;
    endcase
  endfunction

  // right-justify the addressed bytes, lowest address in the low byte
  function automatic logic [31:0] extract(
    input logic [1:0] size,
    input logic [1:0] lo,
    input logic [31:0] w
  );
    logic [31:0] sh;
    sh = w >> {lo, 3'b000};
    case (size)
      mrc_pkg::MRC_SIZE_BYTE: extract = {24'h00_0000, sh[7:0]};
      mrc_pkg::MRC_SIZE_HALF: extract = {16'h0000, sh[15:0]};
      default: extract = sh;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode uses the registered remap bit, so a remap write never splits an access
  assign region = decode(addr_i, s.remap, kernel_run_o);
  assign misaligned = (size_i == mrc_pkg::MRC_SIZE_HALF && addr_i[0]) ||
                      (size_i == mrc_pkg::MRC_SIZE_WORD && addr_i[1:0] != 2'b00) ||
                      (size_i == 2'b11);
  assign offset = (addr_i < mrc_pkg::ALIAS_SIZE) ? addr_i :
                  (region == mrc_pkg::MRC_REGION_SRAM) ? addr_i - mrc_pkg::SRAM_BASE :
                  addr_i - mrc_pkg::FLASH_BASE;
  assign lane_be = byte_enables(size_i, addr_i[1:0]);
  assign lane_data = lane_copy(size_i, wdata_i);
  assign flash_addr_o = offset[mrc_pkg::FLASH_AW-1:0];
  assign mmr_addr_o = addr_i[mrc_pkg::MMR_AW-1:0];
  assign mmr_be_o = lane_be;
  assign mmr_wdata_o = lane_data;
  assign mmr_we_o = we_i;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.abort = 1'b0;
    sram_we = 1'b0;
    sts_wr = 1'b0;
    clr_wr = 1'b0;
    flash_rd_o = 1'b0;
    mmr_req_o = 1'b0;
    word = 32'h0000_0000;
    if (req_i) begin
      next_s.done = 1'b1;
      if (region == mrc_pkg::MRC_REGION_NONE || misaligned) begin
        next_s.abort = 1'b1;
      end else begin
        case (region)
          mrc_pkg::MRC_REGION_SRAM: begin
            sram_we = we_i;
            word = sram_rdata;
          end
          mrc_pkg::MRC_REGION_FLASH: begin
            // flash is programmed through its own controller; direct writes are dropped
            flash_rd_o = !we_i;
            word = flash_rdata_i;
          end
          mrc_pkg::MRC_REGION_MAP: begin
            if (we_i && lane_be[0]) begin
              next_s.remap = wdata_i[mrc_pkg::REMAP_BIT];
            end
            word = {31'h0000_0000, s.remap};
          end
          mrc_pkg::MRC_REGION_STATUS: begin
            sts_wr = we_i && lane_be[0];
            word = {24'h00_0000, status};
          end
          mrc_pkg::MRC_REGION_CLEAR: begin
            clr_wr = we_i && lane_be[0];
          end
          mrc_pkg::MRC_REGION_MMR: begin
            mmr_req_o = 1'b1;
            word = mmr_rdata_i;
          end
          default: begin
            next_s.abort = 1'b1;
          end
        endcase
        if (!we_i) begin
          next_s.rdata = extract(size_i, addr_i[1:0], word);
        end
      end
    end
    if (sys_reset_o) begin
      next_s.remap = mrc_pkg::REMAP_RESET_VALUE;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s.remap <= mrc_pkg::REMAP_RESET_VALUE;
      s.done <= 1'b0;
      s.abort <= 1'b0;
      s.rdata <= 32'h0000_0000;
    end else begin
      s <= next_s;
    end
  end

  assign done_o = s.done;
  assign abort_o = s.abort;
  assign rdata_o = s.rdata;

  ////////////////////////////////////////////////////////////////////////////
  mrc_sram #(
    .WORDS(SRAM_WORDS),
    .AW(mrc_pkg::SRAM_AW)
  ) u_sram (
    .clock_i(clock_i),
    .we_i(sram_we),
    .be_i(lane_be),
    .index_i(offset[mrc_pkg::SRAM_AW+1:2]),
    .wdata_i(lane_data),
    .rdata_o(sram_rdata)
  );

  mrc_reset_ctrl u_reset (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .wdt_timeout_i(wdt_timeout_i),
    .ext_reset_i(ext_reset_i),
    .sts_wr_i(sts_wr),
    .clr_wr_i(clr_wr),
    .wbyte_i(wdata_i[7:0]),
    .lvf_enable_i(lvf_enable_i),
    .low_voltage_flag_i(low_voltage_flag_i),
    .download_done_i(download_done_i),
    .kernel_done_i(kernel_done_i),
    .status_o(status),
    .sys_reset_o(sys_reset_o),
    .wdt_reset_o(wdt_reset_o),
    .kernel_run_o(kernel_run_o),
    .ram_valid_o(ram_valid_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  a_undef_abort: assert property (@(posedge clock_i) disable iff (!resetn_i)
    req_i && addr_i >= 32'h0001_7800 && addr_i < 32'h0004_0000 |=> done_o && abort_o)
    else $error("undefined address did not abort");
  a_remap_write: assert property (@(posedge clock_i) disable iff (!resetn_i)
    req_i && we_i && addr_i == mrc_pkg::MAP_SELECT_ADDR && !misaligned && !sys_reset_o
    |=> s.remap == $past(wdata_i[0]) && !abort_o)
    else $error("map select write did not take effect");
  a_remap_cleared: assert property (@(posedge clock_i) disable iff (!resetn_i)
    sys_reset_o |=> !s.remap)
    else $error("remap survived a reset");
  a_alias_flash: assert property (@(posedge clock_i) disable iff (!resetn_i)
    req_i && !we_i && !s.remap && addr_i < 32'h0001_7800 && !misaligned
    |-> flash_rd_o && flash_addr_o == addr_i[16:0])
    else $error("alias window not mapped to flash");
  a_sram_byte_read: assert property (@(posedge clock_i) disable iff (!resetn_i)
    req_i && !we_i && size_i == 2'b00 && region == mrc_pkg::MRC_REGION_SRAM
    |=> rdata_o[31:8] == 24'h00_0000 && !abort_o)
    else $error("byte read not zero extended");
  a_kernel_hidden: assert property (@(posedge clock_i) disable iff (!resetn_i)
    req_i && !kernel_run_o && addr_i >= 32'h0009_7800 && addr_i < 32'h0009_8000
    |=> abort_o)
    else $error("kernel region reached by user access");
  a_answer_once: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !req_i |=> !done_o && !abort_o)
    else $error("answer without request");
  c_remap_on: cover property (@(posedge clock_i) disable iff (!resetn_i)
    !s.remap ##1 s.remap);
  c_abort_seen: cover property (@(posedge clock_i) disable iff (!resetn_i) abort_o);
  c_sram_alias: cover property (@(posedge clock_i) disable iff (!resetn_i)
    req_i && s.remap && addr_i < 32'h0000_1800);
endmodule

// ===== rtl/mrc_pkg.sv
// shared constants and types for the memory remap and reset control block
package mrc_pkg;
  // memory map
  localparam logic [31:0] ALIAS_SIZE = 32'h0001_7800;
  localparam logic [31:0] SRAM_BASE = 32'h0004_0000;
  localparam logic [31:0] SRAM_SIZE = 32'h0000_1800;
  localparam logic [31:0] FLASH_BASE = 32'h0008_0000;
  localparam logic [31:0] FLASH_SIZE = 32'h0001_8000;
  localparam logic [31:0] KERNEL_SIZE = 32'h0000_0800;
  localparam logic [31:0] MMR_BASE = 32'hFFFF_0000;
  localparam int MMR_PAGE_LSB = 12;
  localparam int FLASH_AW = 17;
  localparam int MMR_AW = 12;
  localparam int SRAM_WORDS = 1536;
  localparam int SRAM_AW = 11;
  // registers
  localparam logic [31:0] MAP_SELECT_ADDR = 32'hFFFF_0220;
  localparam logic [31:0] RST_STATUS_ADDR = 32'hFFFF_0230;
  localparam logic [31:0] RST_CLEAR_ADDR = 32'hFFFF_0234;
  localparam int REG_WIDTH = 8;
  localparam int REMAP_BIT = 0;
  localparam int STS_POR = 0;
  localparam int STS_WDT = 1;
  localparam int STS_SW = 2;
  localparam int STS_EXT = 3;
  localparam int STS_WIDTH = 4;
  localparam logic [STS_WIDTH-1:0] STS_RESET_VALUE = 4'h1;
  localparam logic REMAP_RESET_VALUE = 1'b0;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_PULSE_NS = 50;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CNT_W = 4;

  typedef enum logic [1:0] {MRC_SIZE_BYTE, MRC_SIZE_HALF, MRC_SIZE_WORD} mrc_size_e;
  typedef enum logic [2:0] {
    MRC_REGION_NONE, MRC_REGION_SRAM, MRC_REGION_FLASH, MRC_REGION_MAP,
    MRC_REGION_STATUS, MRC_REGION_CLEAR, MRC_REGION_MMR
  } mrc_region_e;
  typedef enum logic [1:0] {MRC_RST_RUN, MRC_RST_ASSERT, MRC_RST_KERNEL} mrc_rst_e;
endpackage

// ===== rtl/mrc_sram.sv
// word-wide static ram with byte enables and asynchronous read
`timescale 1ns/10ps
module mrc_sram #(
  parameter int WORDS = mrc_pkg::SRAM_WORDS,
  parameter int AW = mrc_pkg::SRAM_AW
) (
  input wire logic clock_i,
  input wire logic we_i,
  input wire logic [3:0] be_i,
  input wire logic [AW-1:0] index_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o
);
  // one byte-wide array per lane, so each array has a single writing process
  // only the enabled lanes change on narrow writes
  for (genvar b = 0; b < 4; b++) begin : g_lane
    logic [7:0] mem [WORDS];
    assign rdata_o[8*b +: 8] = (int'(index_i) < WORDS) ? mem[index_i] : 8'h00;
    always_ff @(posedge clock_i) begin
      if (we_i && be_i[b] && int'(index_i) < WORDS) begin
        mem[index_i] <= wdata_i[8*b +: 8];
      end
    end
  end
endmodule

// ===== rtl/mrc_reset_ctrl.sv
// reset source status, software reset triggering and reset scope control
`timescale 1ns/10ps
module mrc_reset_ctrl (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic wdt_timeout_i,
  input wire logic ext_reset_i,
  input wire logic sts_wr_i,
  input wire logic clr_wr_i,
  input wire logic [7:0] wbyte_i,
  input wire logic lvf_enable_i,
  input wire logic low_voltage_flag_i,
  input wire logic download_done_i,
  input wire logic kernel_done_i,
  output logic [7:0] status_o,
  output logic sys_reset_o,
  output logic wdt_reset_o,
  output logic kernel_run_o,
  output logic ram_valid_o
);
  typedef struct packed {
    mrc_pkg::mrc_rst_e state;
    logic [mrc_pkg::RESET_CNT_W-1:0] cnt;
    logic [mrc_pkg::STS_WIDTH-1:0] sts;
    logic por_pend;
    logic dl_seen;
    logic ram_valid;
  } mrc_rst_s;

  mrc_rst_s s;
  mrc_rst_s next_s;
  logic sw_trig;
  logic any_trig;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    next_s.por_pend = 1'b0;
    // software reset by status write, or by a clear that leaves bit 2 set
    sw_trig = (sts_wr_i && wbyte_i[mrc_pkg::STS_SW]) ||
              (clr_wr_i && s.sts[mrc_pkg::STS_SW] && !wbyte_i[mrc_pkg::STS_SW]);
    any_trig = sw_trig || wdt_timeout_i || ext_reset_i;
    if (s.por_pend) begin
      next_s.ram_valid = lvf_enable_i && low_voltage_flag_i;
    end
    if (download_done_i) begin
      next_s.dl_seen = 1'b1;
    end
    if (clr_wr_i) begin
      next_s.sts = s.sts & ~wbyte_i[mrc_pkg::STS_WIDTH-1:0];
    end
    // sets come after the clear so a same-cycle event wins
    if (wdt_timeout_i) begin
      next_s.sts[mrc_pkg::STS_WDT] = 1'b1;
    end
    if (sw_trig) begin
      next_s.sts[mrc_pkg::STS_SW] = 1'b1;
    end
    if (ext_reset_i) begin
      next_s.sts[mrc_pkg::STS_EXT] = 1'b1;
    end
    case (s.state)
      mrc_pkg::MRC_RST_ASSERT: begin
        next_s.cnt = s.cnt + 1'b1;
        if (s.cnt == mrc_pkg::RESET_CNT_W'(mrc_pkg::RESET_PULSE_CYCLES - 1)) begin
          next_s.state = mrc_pkg::MRC_RST_KERNEL;
        end
      end
      mrc_pkg::MRC_RST_KERNEL: begin
        if (kernel_done_i) begin
          next_s.state = mrc_pkg::MRC_RST_RUN;
        end
      end
      mrc_pkg::MRC_RST_RUN: begin
        next_s.cnt = '0;
      end
      default: begin
        next_s.state = mrc_pkg::MRC_RST_KERNEL;
      end
    endcase
    if (any_trig) begin
      // ram survives these resets unless a download session came before
      next_s.ram_valid = !(s.dl_seen || download_done_i);
      next_s.dl_seen = 1'b0;
      next_s.cnt = '0;
      next_s.state = mrc_pkg::MRC_RST_ASSERT;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s.state <= mrc_pkg::MRC_RST_KERNEL;
      s.cnt <= '0;
      s.sts <= mrc_pkg::STS_RESET_VALUE;
      s.por_pend <= 1'b1;
      s.dl_seen <= 1'b0;
      s.ram_valid <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign status_o = {{(mrc_pkg::REG_WIDTH - mrc_pkg::STS_WIDTH){1'b0}}, s.sts};
  assign sys_reset_o = (s.state == mrc_pkg::MRC_RST_ASSERT);
  // only power-on reaches the watchdog
  assign wdt_reset_o = s.por_pend;
  assign kernel_run_o = (s.state != mrc_pkg::MRC_RST_RUN);
  assign ram_valid_o = s.ram_valid;

  ////////////////////////////////////////////////////////////////////////////
  a_sw_write_trig: assert property (@(posedge clock_i) disable iff (!resetn_i)
    sts_wr_i && wbyte_i[2] |=> sys_reset_o && status_o[2])
    else $error("status write of bit 2 gave no software reset");
  a_clr_retrigger: assert property (@(posedge clock_i) disable iff (!resetn_i)
    clr_wr_i && status_o[2] && !wbyte_i[2] |=> sys_reset_o)
    else $error("clear leaving bit 2 set gave no software reset");
  a_clr_bits_low: assert property (@(posedge clock_i) disable iff (!resetn_i)
    clr_wr_i && !sts_wr_i && !wdt_timeout_i && !ext_reset_i && !(status_o[2] && !wbyte_i[2])
    |=> (status_o[3:0] & $past(wbyte_i[3:0])) == 4'h0)
    else $error("cleared status bit still set");
  a_wdt_sets_bit: assert property (@(posedge clock_i) disable iff (!resetn_i)
    wdt_timeout_i |=> status_o[1] && sys_reset_o)
    else $error("watchdog event not recorded");
  a_ext_sets_bit: assert property (@(posedge clock_i) disable iff (!resetn_i)
    ext_reset_i |=> status_o[3])
    else $error("external reset not recorded");
  a_upper_zero: assert property (@(posedge clock_i) disable iff (!resetn_i)
    status_o[7:4] == 4'h0)
    else $error("unused status bits not zero");
  a_pulse_length: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $rose(sys_reset_o) |-> sys_reset_o [*5] ##1 (kernel_run_o || sys_reset_o))
    else $error("reset pulse too short or kernel not run");
  a_wdt_scope: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $rose(sys_reset_o) |-> !wdt_reset_o)
    else $error("watchdog reset on a non power-on reset");
  a_ram_after_dl: assert property (@(posedge clock_i) disable iff (!resetn_i)
    download_done_i ##1 ((wdt_timeout_i || ext_reset_i) && !download_done_i) [*1] |=> !ram_valid_o)
    else $error("ram reported valid after download and reset");
  c_sw_reset: cover property (@(posedge clock_i) disable iff (!resetn_i)
    sts_wr_i && wbyte_i[2] ##1 sys_reset_o);
  c_kernel_exit: cover property (@(posedge clock_i) disable iff (!resetn_i)
    kernel_run_o ##1 !kernel_run_o);
endmodule

// ===== test/mrc_mem_model.sv
// flash array and register page responder on the far side of the control block
`timescale 1ns/10ps
module mrc_mem_model (
  input wire logic flash_rd_i,
  input wire logic [mrc_pkg::FLASH_AW-1:0] flash_addr_i,
  output logic [31:0] flash_rdata_o,
  input wire logic mmr_req_i,
  input wire logic [mrc_pkg::MMR_AW-1:0] mmr_addr_i,
  output logic [31:0] mmr_rdata_o
);
  logic [31:0] fword;
  logic [31:0] mword;
  // word pattern from the aligned offset, so a lane slip shows at once
  assign fword = {8'hC3, 7'h00, flash_addr_i[16:2], 2'h0};
  assign mword = {20'hD00D0, mmr_addr_i[11:2], 2'h0};
  // unselected: inverse, so a stale read never matches by chance
  assign flash_rdata_o = flash_rd_i ? fword : ~fword;
  assign mmr_rdata_o = mmr_req_i ? mword : ~mword;
endmodule

// ===== test/memory_remap_reset_control_tb.sv
// self-checking bench for the memory remap and reset control block
`timescale 1ns/10ps
module memory_remap_reset_control_tb;
  typedef struct packed {logic [3:0] c; logic [31:0] a; logic [31:0] d;} mrc_row_s;
  logic clock_i, resetn_i, req_i, we_i, wdt_timeout_i, ext_reset_i, lvf_enable_i;
  logic low_voltage_flag_i, download_done_i, kernel_done_i, done_o, abort_o, flash_rd_o;
  logic mmr_req_o, mmr_we_o, sys_reset_o, wdt_reset_o, kernel_run_o, ram_valid_o;
  logic [1:0] size_i;
  logic [31:0] addr_i, wdata_i, rdata_o, flash_rdata_i, mmr_wdata_o, mmr_rdata_i;
  logic [mrc_pkg::FLASH_AW-1:0] flash_addr_o;
  logic [mrc_pkg::MMR_AW-1:0] mmr_addr_o;
  logic [3:0] mmr_be_o;
  int errors = 0;
  int n_tests = 0;
  mrc_row_s rows[$];
  mrc_top mrc_top_inst (.clock_i, .resetn_i, .req_i, .we_i, .size_i, .addr_i, .wdata_i,
    .done_o, .abort_o, .rdata_o, .flash_rd_o, .flash_addr_o, .flash_rdata_i, .mmr_req_o,
    .mmr_we_o, .mmr_addr_o, .mmr_be_o, .mmr_wdata_o, .mmr_rdata_i, .wdt_timeout_i,
    .ext_reset_i, .lvf_enable_i, .low_voltage_flag_i, .download_done_i, .kernel_done_i,
    .sys_reset_o, .wdt_reset_o, .kernel_run_o, .ram_valid_o);
  mrc_mem_model mrc_mem_model_inst (.flash_rd_i(flash_rd_o), .flash_addr_i(flash_addr_o),
    .flash_rdata_o(flash_rdata_i), .mmr_req_i(mmr_req_o), .mmr_addr_i(mmr_addr_o),
    .mmr_rdata_o(mmr_rdata_i));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // request left high so calls run back to back
  task automatic acc(input logic w, input logic [1:0] s, input logic [31:0] a,
                     input logic [31:0] d);
    req_i = 1'h1;
    we_i = w;
    size_i = s;
    addr_i = a;
    wdata_i = d;
    @(negedge clock_i);
    check("done", 32'(done_o), 32'h1);
  endtask
  task automatic rst_wait();
    int n;
    n = 0;
    req_i = 1'h0;
    wdt_timeout_i = 1'h0;
    ext_reset_i = 1'h0;
    // the pulse is already up at the call, one cycle after the trigger was taken
    repeat (12) begin
      if (sys_reset_o === 1'h1) n++;
      @(negedge clock_i);
    end
    check("pulse", 32'(n), 32'(mrc_pkg::RESET_PULSE_CYCLES));
    check("kernel", 32'(kernel_run_o), 32'h1);
    check("wdtrst", 32'(wdt_reset_o), 32'h0);
    kernel_done_i = 1'h1;
    @(negedge clock_i);
    kernel_done_i = 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'h0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    #20000;
    errors++;
    final_report();
  end
  initial begin
    mrc_row_s r;
    {resetn_i, req_i, we_i, wdt_timeout_i, ext_reset_i, lvf_enable_i} = 6'h0;
    {low_voltage_flag_i, download_done_i, kernel_done_i, size_i} = 5'h0;
    addr_i = 32'h0;
    wdata_i = 32'h0;
    // c: bit3 abort expected, bit2 write, bits 1:0 size
    rows = '{{4'h6, 32'h0004_0000, 32'h1122_3344}, {4'h4, 32'h0004_0001, 32'h0000_00AA},
      {4'h2, 32'h0004_0000, 32'h1122_AA44}, {4'h5, 32'h0004_0002, 32'h0000_BEEF},
      {4'h1, 32'h0004_0002, 32'h0000_BEEF}, {4'h0, 32'h0004_0003, 32'h0000_00BE},
      {4'h6, 32'h0004_17FC, 32'h5A5A_5A5A}, {4'h2, 32'h0004_17FC, 32'h5A5A_5A5A},
      {4'hA, 32'h0004_1800, 32'h0}, {4'h2, 32'h0000_0004, 32'hC300_0004},
      {4'h2, 32'h0001_77FC, 32'hC301_77FC}, {4'hA, 32'h0001_7800, 32'h0},
      {4'h2, 32'h0008_0008, 32'hC300_0008}, {4'hA, 32'h0009_7800, 32'h0},
      {4'hA, 32'h1000_0000, 32'h0}, {4'hC, 32'h1000_0000, 32'h0},
      {4'hA, 32'h0004_0001, 32'h0}, {4'hB, 32'h0004_0000, 32'h0},
      {4'h2, 32'hFFFF_0400, 32'hD00D_0400}, {4'hA, 32'hFFFE_FFFC, 32'h0},
      {4'h0, 32'hFFFF_0230, 32'h0000_0001}, {4'h0, 32'hFFFF_0220, 32'h0},
      {4'h0, 32'hFFFF_0234, 32'h0}};
    repeat (2) @(negedge clock_i);
    resetn_i = 1'h1;
    kernel_done_i = 1'h1;
    @(negedge clock_i);
    kernel_done_i = 1'h0;
    @(negedge clock_i);
    foreach (rows[i]) begin
      r = rows[i];
      acc(r.c[2], r.c[1:0], r.a, r.d);
      check("abort", 32'(abort_o), 32'(r.c[3]));
      if (!r.c[2] && !r.c[3]) check("rdata", rdata_o, r.d);
    end
    // register page outputs still show the request at the answer's edge
    acc(1'h1, 2'h0, 32'hFFFF_0401, 32'h0000_005A);
    check("mmrbe", 32'(mmr_be_o), 32'h2);
    check("mmrwd", mmr_wdata_o, 32'h5A5A_5A5A);
    check("mmrwe", 32'(mmr_we_o), 32'h1);
    // software keeps the unused map select bits at zero
    acc(1'h1, 2'h0, mrc_pkg::MAP_SELECT_ADDR, 32'h1);
    acc(1'h0, 2'h2, 32'h0, 32'h0);
    check("remap", rdata_o, 32'hBEEF_AA44);
    acc(1'h0, 2'h0, mrc_pkg::MAP_SELECT_ADDR, 32'h0);
    check("mapsel", rdata_o, 32'h1);
    acc(1'h1, 2'h0, mrc_pkg::MAP_SELECT_ADDR, 32'h0);
    acc(1'h0, 2'h2, 32'h0, 32'h0);
    check("unmap", rdata_o, 32'hC300_0000);
    acc(1'h1, 2'h0, mrc_pkg::MAP_SELECT_ADDR, 32'h1);
    acc(1'h1, 2'h0, mrc_pkg::RST_STATUS_ADDR, 32'h4);
    rst_wait();
    acc(1'h0, 2'h2, 32'h0, 32'h0);
    check("boot", rdata_o, 32'hC300_0000);
    check("ramok", 32'(ram_valid_o), 32'h1);
    acc(1'h0, 2'h0, mrc_pkg::RST_STATUS_ADDR, 32'h0);
    check("status", rdata_o, 32'h5);
    acc(1'h1, 2'h0, mrc_pkg::RST_CLEAR_ADDR, 32'h1);
    rst_wait();
    acc(1'h0, 2'h0, mrc_pkg::RST_STATUS_ADDR, 32'h0);
    check("status", rdata_o, 32'h4);
    acc(1'h1, 2'h0, mrc_pkg::RST_CLEAR_ADDR, 32'h4);
    acc(1'h0, 2'h0, mrc_pkg::RST_STATUS_ADDR, 32'h0);
    check("status", rdata_o, 32'h0);
    check("norst", 32'(sys_reset_o), 32'h0);
    for (int k = 0; k < 2; k++) begin
      req_i = 1'h0;
      download_done_i = 1'(k);
      @(negedge clock_i);
      download_done_i = 1'h0;
      wdt_timeout_i = (k == 0);
      ext_reset_i = (k == 1);
      @(negedge clock_i);
      rst_wait();
      check("ramok", 32'(ram_valid_o), 32'(k == 0));
      acc(1'h0, 2'h0, mrc_pkg::RST_STATUS_ADDR, 32'h0);
      check("status", rdata_o, k ? 32'hA : 32'h2);
    end
    for (int k = 0; k < 2; k++) begin
      req_i = 1'h0;
      lvf_enable_i = 1'h1;
      low_voltage_flag_i = 1'(k);
      resetn_i = 1'h0;
      @(negedge clock_i);
      check("wdtrst", 32'(wdt_reset_o), 32'h1);
      resetn_i = 1'h1;
      @(negedge clock_i);
      check("ramok", 32'(ram_valid_o), 32'(k));
      acc(1'h0, 2'h0, mrc_pkg::RST_STATUS_ADDR, 32'h0);
      check("status", rdata_o, 32'h1);
    end
    final_report();
  end
endmodule
